//--- rtl/tle_alert_core.sv
// Temperature limit registers, comparison flags and alert pin control
`timescale 1ns/1ps
// Operation
// - Limits hold 11-bit two's complement values
// - Bit 15 flags above critical limit
// - Bit 14 flags above high limit
// - Bit 13 flags below low limit
// - Two's complement coding, bit 12 sign
// - Reading stored as 13-bit signed, 0.0625 steps
// - Fine bits only when resolution allows
// - Limit bits 1 and 0 read zero
// - Interrupt mode latches alert on window crossings
// - Writing clear deasserts latched alert
// - Above critical, alert held and uncleared
// - Clear above critical is deferred, remembered
// - Comparator mode: alert outside window
// - Critical-only: alert only above critical
// - Comparator mode ignores clear requests
// - Critical and high trip above the limit, release below limit minus hysteresis; low the reverse
// - Shutdown stops updates, freezes reading
// - Shutdown keeps alert in prior state, unless an interrupt-mode clear below critical drops it
// - Limit writes re-evaluate the alert three cycles after the limit register loads
// - Reading refreshed once per sample period
// - Hysteresis codes: 0, 1.5, 3, 6 degrees
// - Disabled output floats or grounds per polarity
// - Critical-only select limits events to critical
// - Shutdown bit stops, clearing resumes sampling
module tle_alert_core
  import tle_pkg::*;
#(
  parameter int TEMP_W = TLE_TEMP_W // Width of the signed reading
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register access from the serial front end, same clock
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [3:0] reg_ptr,
  input wire logic [15:0] reg_wr_data,
  output logic [15:0] reg_rd_data,
  // Converter output, one pulse per sampling period
  input wire logic sample_valid,
  input wire logic [12:0] sample_value,
  // Configuration bits held elsewhere
  input wire logic [15:0] high_limit_word,
  input wire logic [1:0] hysteresis_select,
  input wire logic sensor_shutdown,
  input wire logic clear_request,
  input wire logic alert_output_enable,
  input wire logic critical_only_select,
  input wire logic alert_polarity,
  input wire logic interrupt_mode,
  input wire logic [1:0] resolution_capability,
  // Status and pin
  output logic alert_status,
  output logic measured_update,
  output logic alert_pin_o,
  output logic alert_pin_oe
);

  // Only the documented 13-bit reading is supported
  if (TEMP_W != TLE_TEMP_W) begin : g_width_check
    $error("tle_alert_core: TEMP_W must be 13");
  end

  logic [15:0] lower_limit_word; // Low limit as read back
  logic [15:0] crit_limit_word; // Critical limit as read back
  logic lower_wr; // Write strobe for the low limit
  logic crit_wr; // Write strobe for the critical limit
  logic [7:0] band_amount; // Selected hysteresis in reading steps
  logic crit_above; // Temperature above critical trip
  logic high_above; // Temperature above high trip
  logic low_above; // Temperature above low trip (inverted flag)

  logic [12:0] temp_r; // Frozen or live reading
  logic [12:0] temp_nxt;
  logic [2:0] flags_r; // Crit, high, low flags of the measured word
  logic [2:0] flags_nxt;
  logic [2:0] prev_flags_r; // Flags one cycle ago for crossing detect
  logic update_r; // One-cycle pulse on a reading refresh
  logic update_nxt;

  tle_int_state_e int_st_r; // Interrupt-mode event latch
  tle_int_state_e int_st_nxt;
  logic asserted_r; // Alert asserted, polarity independent
  logic asserted_nxt;
  logic pin_o_r;
  logic pin_o_nxt;
  logic pin_oe_r;
  logic pin_oe_nxt;
  logic [15:0] rd_data_r;
  logic [15:0] rd_data_nxt;

  // Limit write decode; the measured word is read-only
  assign lower_wr = reg_wr_en && reg_ptr == TLE_PTR_LOWER_LIMIT;
  assign crit_wr = reg_wr_en && reg_ptr == TLE_PTR_CRIT_LIMIT;

  // Low limit register
  tle_limit_reg u_lower_limit (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(lower_wr),
    .wr_data(reg_wr_data),
    .limit_word(lower_limit_word)
  );

  // Critical limit register
  tle_limit_reg u_crit_limit (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(crit_wr),
    .wr_data(reg_wr_data),
    .limit_word(crit_limit_word)
  );

  // Hysteresis decode
  always_comb begin
    case (hysteresis_select)
      TLE_HSEL_NONE: band_amount = TLE_HYSTERESIS_NONE;
      TLE_HSEL_1P5: band_amount = TLE_HYSTERESIS_1P5;
      TLE_HSEL_3P0: band_amount = TLE_HYSTERESIS_3P0;
      TLE_HSEL_6P0: band_amount = TLE_HYSTERESIS_6P0;
      default: band_amount = TLE_HYSTERESIS_NONE;
    endcase
  end

  // Comparators are registered, so a limit write reaches their outputs one cycle after the limit loads
  tle_trip_cmp u_cmp_crit (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .temp(temp_r),
    .limit_word(crit_limit_word),
    .release_band(band_amount),
    .above(crit_above)
  );

  tle_trip_cmp u_cmp_high (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .temp(temp_r),
    .limit_word(high_limit_word),
    .release_band(band_amount),
    .above(high_above)
  );

  tle_trip_cmp u_cmp_low (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .temp(temp_r),
    .limit_word(lower_limit_word),
    .release_band(band_amount),
    .above(low_above)
  );

  // Reading capture: refresh per sample unless shut down
  always_comb begin
    temp_nxt = temp_r;
    update_nxt = 1'b0;
    if (sample_valid && !sensor_shutdown) begin
      temp_nxt = sample_value;
      update_nxt = 1'b1;
      // Mask fractional bits the converter does not resolve
      case (resolution_capability)
        TLE_RES_HALF: temp_nxt[2:0] = 3'h0;
        TLE_RES_QUARTER: temp_nxt[1:0] = 2'h0;
        TLE_RES_EIGHTH: temp_nxt[0] = 1'b0;
        default: temp_nxt = sample_value;
      endcase
    end
  end

  // Flags follow the comparators every cycle
  always_comb begin
    flags_nxt[2] = crit_above;
    flags_nxt[1] = high_above;
    flags_nxt[0] = !low_above;
  end

  // Reading and flag registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      temp_r <= TLE_MEASURED_RESET[12:0];
      flags_r <= 3'h0;
      prev_flags_r <= 3'h0;
      update_r <= 1'b0;
    end else begin
      temp_r <= temp_nxt;
      flags_r <= flags_nxt;
      prev_flags_r <= flags_r;
      update_r <= update_nxt;
    end
  end

  // Alert decision. Crossings are edges of the registered flags, so a
  // limit write shows up two cycles later, well inside one bus access.
  always_comb begin
    logic window_cross;
    logic crit_cross;
    logic crit_fell;
    logic outside;
    window_cross = (flags_r[1] != prev_flags_r[1]) || (flags_r[0] != prev_flags_r[0]);
    crit_cross = flags_r[2] != prev_flags_r[2];
    crit_fell = prev_flags_r[2] && !flags_r[2];
    outside = flags_r[1] || flags_r[0] || flags_r[2];
    int_st_nxt = int_st_r;
    asserted_nxt = asserted_r;
    if (sensor_shutdown) begin
      // Hold the pin as it was; only a clear may still drop a latched event
      if (interrupt_mode && !critical_only_select && clear_request
          && !flags_r[2]) begin
        int_st_nxt = TLE_ST_IDLE;
        asserted_nxt = 1'b0;
      end
    end else if (critical_only_select) begin
      // Only the critical trip drives the pin; clears do nothing here
      int_st_nxt = TLE_ST_IDLE;
      asserted_nxt = flags_r[2];
    end else if (!interrupt_mode) begin
      int_st_nxt = TLE_ST_IDLE;
      asserted_nxt = outside;
    end else begin
      case (int_st_r)
        TLE_ST_IDLE: begin
          if (window_cross || crit_cross || flags_r[2]) begin
            int_st_nxt = TLE_ST_LATCHED;
          end
        end
        TLE_ST_LATCHED: begin
          if (clear_request && flags_r[2]) begin
            int_st_nxt = TLE_ST_CLR_PEND;
          end else if (clear_request && !window_cross && !crit_cross) begin
            int_st_nxt = TLE_ST_IDLE;
          end
        end
        TLE_ST_CLR_PEND: begin
          // Deferred clear runs once the reading drops below critical
          if (crit_fell && !window_cross) begin
            int_st_nxt = TLE_ST_IDLE;
          end else if (!flags_r[2] && window_cross) begin
            int_st_nxt = TLE_ST_LATCHED;
          end
        end
        default: int_st_nxt = TLE_ST_IDLE;
      endcase
      // Above critical the alert stays on whatever was requested
      asserted_nxt = (int_st_nxt != TLE_ST_IDLE) || flags_r[2];
    end
  end

  // Pin drive: open drain, low is the only driven level
  always_comb begin
    pin_o_nxt = 1'b0;
    pin_oe_nxt = 1'b0;
    if (!alert_output_enable) begin
      pin_oe_nxt = alert_polarity;
    end else if (alert_polarity) begin
      pin_oe_nxt = !asserted_nxt;
    end else begin
      pin_oe_nxt = asserted_nxt;
    end
  end

  // Read mux, one cycle after the read strobe; unknown pointers read zero
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (reg_rd_en) begin
      case (reg_ptr)
        TLE_PTR_LOWER_LIMIT: rd_data_nxt = lower_limit_word;
        TLE_PTR_CRIT_LIMIT: rd_data_nxt = crit_limit_word;
        TLE_PTR_MEASURED: rd_data_nxt = {flags_r, temp_r};
        default: rd_data_nxt = 16'h0000;
      endcase
    end
  end

  // Alert, pin and read registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_st_r <= TLE_ST_IDLE;
      asserted_r <= 1'b0;
      pin_o_r <= 1'b0;
      pin_oe_r <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      int_st_r <= int_st_nxt;
      asserted_r <= asserted_nxt;
      pin_o_r <= pin_o_nxt;
      pin_oe_r <= pin_oe_nxt;
      rd_data_r <= rd_data_nxt;
    end
  end

  // Status copy is gated by the output enable, independent of polarity
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      alert_status <= 1'b0;
    end else begin
      alert_status <= asserted_nxt && alert_output_enable;
    end
  end

  assign reg_rd_data = rd_data_r;
  assign measured_update = update_r;
  assign alert_pin_o = pin_o_r;
  assign alert_pin_oe = pin_oe_r;

endmodule : tle_alert_core

//--- rtl/tle_pkg.sv
// Shared constants for the temperature limit and alert logic
package tle_pkg;

  // Register pointers, as presented by the serial front end
  localparam logic [3:0] TLE_PTR_LOWER_LIMIT = 4'h3;
  localparam logic [3:0] TLE_PTR_CRIT_LIMIT = 4'h4;
  localparam logic [3:0] TLE_PTR_MEASURED = 4'h5;

  // Word layout shared by all temperature registers
  localparam int TLE_WORD_W = 16;
  localparam int TLE_TEMP_W = 13;
  localparam int TLE_SIGN_BIT = 12;
  localparam int TLE_CRIT_FLAG_BIT = 15;
  localparam int TLE_HIGH_FLAG_BIT = 14;
  localparam int TLE_LOW_FLAG_BIT = 13;
  localparam int TLE_LIMIT_MSB = 12;
  localparam int TLE_LIMIT_LSB = 2;

  // Reset values
  localparam logic [15:0] TLE_LIMIT_RESET = 16'h0000;
  localparam logic [15:0] TLE_MEASURED_RESET = 16'h0000;

  // Hysteresis in 0.0625 degree steps: 1.5, 3 and 6 degrees
  localparam logic [7:0] TLE_HYSTERESIS_NONE = 8'h00;
  localparam logic [7:0] TLE_HYSTERESIS_1P5 = 8'h18;
  localparam logic [7:0] TLE_HYSTERESIS_3P0 = 8'h30;
  localparam logic [7:0] TLE_HYSTERESIS_6P0 = 8'h60;

  // Hysteresis select codes
  localparam logic [1:0] TLE_HSEL_NONE = 2'h0;
  localparam logic [1:0] TLE_HSEL_1P5 = 2'h1;
  localparam logic [1:0] TLE_HSEL_3P0 = 2'h2;
  localparam logic [1:0] TLE_HSEL_6P0 = 2'h3;

  // Resolution capability codes: 9, 10, 11 or 12 fractional-limited bits
  localparam logic [1:0] TLE_RES_HALF = 2'h0;
  localparam logic [1:0] TLE_RES_QUARTER = 2'h1;
  localparam logic [1:0] TLE_RES_EIGHTH = 2'h2;
  localparam logic [1:0] TLE_RES_SIXTEENTH = 2'h3;

  // Interrupt-mode latch states, Gray coded along the usual path
  typedef enum logic [1:0] {
    TLE_ST_IDLE = 2'b00,
    TLE_ST_LATCHED = 2'b01,
    TLE_ST_CLR_PEND = 2'b11
  } tle_int_state_e;

endpackage : tle_pkg

//--- rtl/tle_limit_reg.sv
// One limit register holding an 11-bit two's complement trip point
`timescale 1ns/1ps
module tle_limit_reg
  import tle_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] limit_word
);

  logic [10:0] field_r; // Sign plus ten magnitude bits
  logic [10:0] field_nxt;

  // Keep only bits 12..2; a write simply replaces the field
  always_comb begin
    field_nxt = field_r;
    if (wr_en) begin
      field_nxt = wr_data[TLE_LIMIT_MSB:TLE_LIMIT_LSB];
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      field_r <= TLE_LIMIT_RESET[TLE_LIMIT_MSB:TLE_LIMIT_LSB];
    end else begin
      field_r <= field_nxt;
    end
  end

  // Top three bits and the two trailing bits always read back as zero
  assign limit_word = {3'h0, field_r, 2'h0};

endmodule : tle_limit_reg

//--- rtl/tle_trip_cmp.sv
// Threshold comparator with falling-side hysteresis
`timescale 1ns/1ps
module tle_trip_cmp
  import tle_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [12:0] temp,
  input wire logic [15:0] limit_word,
  input wire logic [7:0] release_band,
  output logic above
);

  logic above_r; // Registered comparison state
  logic above_nxt;
  logic signed [14:0] temp_s; // Widened so the subtraction cannot wrap
  logic signed [14:0] trip_s;
  logic signed [14:0] release_s;

  // Set above the limit, release below limit minus hysteresis, or at the limit when there is none
  always_comb begin
    temp_s = 15'(signed'(temp));
    trip_s = 15'(signed'(limit_word[TLE_SIGN_BIT:0]));
    release_s = trip_s - signed'({7'h00, release_band});
    above_nxt = above_r;
    if (temp_s > trip_s) begin
      above_nxt = 1'b1;
    end else if (temp_s < release_s) begin
      above_nxt = 1'b0;
    end else if (temp_s <= trip_s && release_band == TLE_HYSTERESIS_NONE) begin
      // Without hysteresis, equality counts as not above
      above_nxt = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      above_r <= 1'b0;
    end else begin
      above_r <= above_nxt;
    end
  end

  assign above = above_r;

endmodule : tle_trip_cmp

//--- tb/tle_alert_core_sva.sv
// Port-level assertions for the temperature alert core
`timescale 1ns/1ps
module tle_alert_core_sva
  import tle_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [3:0] reg_ptr,
  input wire logic [15:0] reg_wr_data,
  input wire logic [15:0] reg_rd_data,
  input wire logic sample_valid,
  input wire logic [12:0] sample_value,
  input wire logic [15:0] high_limit_word,
  input wire logic sensor_shutdown,
  input wire logic clear_request,
  input wire logic alert_output_enable,
  input wire logic critical_only_select,
  input wire logic alert_polarity,
  input wire logic interrupt_mode,
  input wire logic [1:0] resolution_capability,
  input wire logic measured_update,
  input wire logic alert_pin_o,
  input wire logic alert_pin_oe
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Limit write followed, after the host's idle cycle, by a read of the same register
  sequence s_wr_rd;
    (reg_wr_en && (reg_ptr == TLE_PTR_LOWER_LIMIT || reg_ptr == TLE_PTR_CRIT_LIMIT))
      ##2 (reg_rd_en && reg_ptr == $past(reg_ptr, 2));
  endsequence
  // Full-resolution sample read back on the next cycle
  sequence s_smp_rd;
    (sample_valid && !sensor_shutdown && resolution_capability == TLE_RES_SIXTEENTH)
      ##1 (reg_rd_en && reg_ptr == TLE_PTR_MEASURED);
  endsequence
  // Window mode, active-low pin, accepted sample above the high limit
  sequence s_cmp_hit;
    !interrupt_mode && !critical_only_select && alert_output_enable && !alert_polarity
      && sample_valid && !sensor_shutdown
      && $signed(sample_value) > $signed(high_limit_word[12:0]);
  endsequence
  // Shut down with nothing left that may move the pin
  sequence s_quiet;
    sensor_shutdown && !clear_request && !reg_wr_en
      && $stable(alert_polarity) && $stable(alert_output_enable);
  endsequence
  property p_limit_rd;
    s_wr_rd |=> reg_rd_data == ($past(reg_wr_data, 3) & 16'h1FFC);
  endproperty
  a_limit_rd: assert property (p_limit_rd) else $error("limit read");
  property p_smp_rd;
    s_smp_rd |=> reg_rd_data[12:0] == $past(sample_value, 2);
  endproperty
  a_smp_rd: assert property (p_smp_rd) else $error("reading");
  property p_upd;
    sample_valid && !sensor_shutdown |-> ##[1:2] measured_update;
  endproperty
  a_upd: assert property (p_upd) else $error("no update");
  property p_noupd;
    sensor_shutdown [*4] |-> !measured_update;
  endproperty
  a_noupd: assert property (p_noupd) else $error("update in shutdown");
  property p_cmp_hit;
    s_cmp_hit |-> ##[3:4] alert_pin_oe;
  endproperty
  a_cmp_hit: assert property (p_cmp_hit) else $error("no alert");
  // Slow settling of a polarity change is allowed by the four-cycle lead
  property p_disabled;
    (!alert_output_enable && $stable(alert_polarity)) [*4] |-> alert_pin_oe == alert_polarity;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled pin");
  property p_freeze;
    s_quiet [*6] |-> $stable(alert_pin_oe);
  endproperty
  a_freeze: assert property (p_freeze) else $error("pin moved");
  // Open drain: the data side of the pin never drives high
  property p_od;
    alert_pin_o == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
endmodule : tle_alert_core_sva

bind tle_alert_core tle_alert_core_sva tle_alert_core_sva_i (.*);

//--- tb/tle_host_model.sv
// Host on the register path: register strobes and clear pulses
`timescale 1ns/1ps
module tle_host_model
  import tle_pkg::*;
(
  input wire logic sys_clk,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [3:0] reg_ptr,
  output logic [15:0] reg_wr_data,
  output logic clear_request,
  input wire logic [15:0] reg_rd_data
);
  // Idle at time zero
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_ptr = 4'h0;
    reg_wr_data = 16'h0000;
    clear_request = 1'b0;
  end
  // Each task starts and ends at a falling edge, so calls run back to back
  task automatic wr(input logic [3:0] p, input logic [15:0] d);
    reg_ptr = p;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
    reg_wr_data = ~d; // Released data shows no stale value
    @(negedge sys_clk); // Idle cycle keeps back-to-back strobes apart
  endtask : wr
  task automatic rd(input logic [3:0] p, output logic [15:0] d);
    reg_ptr = p;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    d = reg_rd_data;
    @(negedge sys_clk); // Idle cycle keeps back-to-back strobes apart
  endtask : rd
  // One-cycle pulse, as when a one lands in the clear bit
  task automatic clr();
    clear_request = 1'b1;
    @(negedge sys_clk);
    clear_request = 1'b0;
  endtask : clr
endmodule : tle_host_model

//--- tb/tle_alert_core_tb.sv
// Self-checking bench for the alert core, host model on the register path
`timescale 1ns/1ps
module tle_alert_core_tb
  import tle_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sample_valid = 1'b0;
  logic [12:0] sample_value = 13'h0000;
  logic [1:0] hysteresis_select = 2'h0;
  logic sensor_shutdown = 1'b0;
  logic alert_output_enable = 1'b1;
  logic critical_only_select = 1'b0;
  logic alert_polarity = 1'b0;
  logic interrupt_mode = 1'b0;
  logic [1:0] resolution_capability = 2'h3;
  logic [15:0] high_limit_word = 16'h0320; // High limit of 50 degrees, held elsewhere
  logic reg_wr_en, reg_rd_en, clear_request;
  logic [3:0] reg_ptr;
  logic [15:0] reg_wr_data, reg_rd_data;
  logic alert_status, measured_update, alert_pin_o, alert_pin_oe;
  int fails = 0;
  int n_checks = 0;
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  tle_alert_core tle_alert_core_i (.*);
  tle_host_model tle_host_model_i (.*);
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16
  task automatic chk_pin(input logic e);
    n_checks++;
    if (alert_pin_oe !== e) begin
      fails++;
      $display("[FAIL] alert_pin_oe expected %b seen %b", e, alert_pin_oe);
    end
  endtask : chk_pin
  task automatic rchk(input logic [3:0] p, input logic [15:0] e);
    logic [15:0] d;
    tle_host_model_i.rd(p, d);
    chk16("reg_rd_data", e, d);
  endtask : rchk
  // Pin settles within four cycles of a sample or a setting
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask : settle
  task automatic samp(input logic [12:0] v);
    sample_value = v;
    sample_valid = 1'b1;
    @(negedge sys_clk);
    sample_valid = 1'b0;
    sample_value = ~v; // Converter bus shows no stale value
    settle();
  endtask : samp
  task automatic t_limits();
    // Reading 0 equals the cleared low limit, which counts as below it
    for (int p = 3; p <= 6; p++) begin
      rchk(p[3:0], (p == 5) ? 16'h2000 : 16'h0000);
    end
    tle_host_model_i.wr(TLE_PTR_LOWER_LIMIT, 16'hFFFF);
    rchk(TLE_PTR_LOWER_LIMIT, 16'h1FFC);
    tle_host_model_i.wr(TLE_PTR_CRIT_LIMIT, 16'hE7D3);
    rchk(TLE_PTR_CRIT_LIMIT, 16'h07D0);
    tle_host_model_i.wr(TLE_PTR_MEASURED, 16'h1234);
    rchk(TLE_PTR_MEASURED, 16'h0000);
    tle_host_model_i.wr(TLE_PTR_LOWER_LIMIT, 16'hE193);
  endtask : t_limits
  task automatic t_flags();
    logic [15:0] d;
    sample_value = 13'h0200;
    sample_valid = 1'b1;
    @(negedge sys_clk);
    sample_valid = 1'b0;
    tle_host_model_i.rd(TLE_PTR_MEASURED, d);
    chk16("reading", 16'h0200, d & 16'h1FFF);
    samp(13'h0400);
    rchk(TLE_PTR_MEASURED, 16'h4400);
    samp(13'h07E0);
    rchk(TLE_PTR_MEASURED, 16'hC7E0);
    samp(13'h1E70);
    rchk(TLE_PTR_MEASURED, 16'h3E70);
    for (int r = 0; r < 4; r++) begin
      resolution_capability = r[1:0];
      samp(13'h0207);
      rchk(TLE_PTR_MEASURED, 16'h0207 & ~(16'h0007 >> r));
    end
  endtask : t_flags
  task automatic t_cmp();
    samp(13'h0200);
    chk_pin(1'b0);
    samp(13'h0400);
    chk_pin(1'b1);
    chk16("alert_status", 16'h0001, {15'h0000, alert_status});
    tle_host_model_i.clr();
    settle();
    chk_pin(1'b1);
    samp(13'h0100);
    chk_pin(1'b1);
    alert_polarity = 1'b1;
    settle();
    chk_pin(1'b0);
    alert_polarity = 1'b0;
    samp(13'h0200);
    // Raising the low limit above the reading must trip the pin
    tle_host_model_i.wr(TLE_PTR_LOWER_LIMIT, 16'h0300);
    settle();
    chk_pin(1'b1);
    tle_host_model_i.wr(TLE_PTR_LOWER_LIMIT, 16'h0190);
    settle();
    chk_pin(1'b0);
  endtask : t_cmp
  task automatic t_crit();
    critical_only_select = 1'b1;
    samp(13'h0400);
    chk_pin(1'b0);
    samp(13'h07E0);
    chk_pin(1'b1);
    samp(13'h0200);
    critical_only_select = 1'b0;
  endtask : t_crit
  task automatic t_int();
    interrupt_mode = 1'b1;
    tle_host_model_i.clr();
    settle();
    chk_pin(1'b0);
    samp(13'h0400);
    chk_pin(1'b1);
    samp(13'h0200);
    chk_pin(1'b1);
    tle_host_model_i.clr();
    settle();
    chk_pin(1'b0);
    samp(13'h07E0);
    tle_host_model_i.clr();
    settle();
    chk_pin(1'b1);
    // Pending clear runs once the reading drops under the critical limit
    samp(13'h0400);
    chk_pin(1'b0);
    samp(13'h0200);
    tle_host_model_i.clr();
    interrupt_mode = 1'b0;
  endtask : t_int
  task automatic t_shutdown();
    samp(13'h0400);
    sensor_shutdown = 1'b1;
    samp(13'h0200);
    chk_pin(1'b1);
    rchk(TLE_PTR_MEASURED, 16'h4400);
    alert_output_enable = 1'b0;
    settle();
    chk_pin(1'b0);
    alert_output_enable = 1'b1;
    sensor_shutdown = 1'b0;
    samp(13'h0200);
    rchk(TLE_PTR_MEASURED, 16'h0200);
    chk_pin(1'b0);
  endtask : t_shutdown
  task automatic t_hysteresis();
    logic [7:0] hv [4] = '{TLE_HYSTERESIS_NONE, TLE_HYSTERESIS_1P5, TLE_HYSTERESIS_3P0,
                           TLE_HYSTERESIS_6P0};
    for (int h = 0; h < 4; h++) begin
      hysteresis_select = h[1:0];
      samp(13'h0330);
      chk_pin(1'b1);
      samp(13'h0321 - hv[h]);
      chk_pin(1'b1);
      samp(13'h031F - hv[h]);
      chk_pin(1'b0);
    end
    hysteresis_select = 2'h0;
  endtask : t_hysteresis
  task automatic t_dis();
    alert_output_enable = 1'b0;
    samp(13'h0400);
    chk_pin(1'b0);
    alert_polarity = 1'b1;
    settle();
    chk_pin(1'b1);
    alert_polarity = 1'b0;
    alert_output_enable = 1'b1;
  endtask : t_dis
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // Reset for six cycles, then the scenarios in turn
  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    t_limits();
    t_flags();
    t_cmp();
    t_crit();
    t_int();
    t_shutdown();
    t_hysteresis();
    t_dis();
    final_report();
  end
  // Watchdog: a hang counts as a mismatch
  initial begin
    #100000;
    fails++;
    final_report();
  end
endmodule : tle_alert_core_tb
